// ### design/pcfg_flex_pin.sv
/*
  One flexible pin driver: direction control and output source mux.
  Assumes notification levels and debug signals are synchronous to
  i_clock.
*/
module pcfg_flex_pin (
  input  wire logic                       i_clock,
  input  wire logic                       i_arst_n,
  input  wire pcfg_pkg::pcfg_pin_cfg_type i_cfg,
  input  wire pcfg_pkg::pcfg_notify_type  i_notify,
  input  wire logic                       i_clkmon_status,
  input  wire logic [2:0]                 i_debug,
  input  wire logic                       i_pin_in,
  output logic                            o_pin_out,
  output logic                            o_pin_oe,
  output logic                            o_pin_value
);

  // ==========================================================
  // state
  typedef struct packed {
    logic out;
    logic oe;
    logic value;
  } pcfg_pin_state_type;

  pcfg_pin_state_type state_d;
  pcfg_pin_state_type state_q;
  logic               or_pll;
  logic               or_clkmon;
  logic               mux_value;

  assign or_pll    = |{i_notify.loss_of_lock, i_notify.holdover_freeze};
  assign or_clkmon = |{i_notify.clock_loss, i_notify.freq_drift};

  // ==========================================================
  // source mux
  always_comb begin
    case (pcfg_pkg::pcfg_mux_type'(i_cfg.mux_sel))
      pcfg_pkg::MUX_CONST_LOW:    mux_value = 1'b0;
      pcfg_pkg::MUX_OR_ALL:       mux_value = or_pll | or_clkmon;
      pcfg_pkg::MUX_OR_PLL:       mux_value = or_pll;
      pcfg_pkg::MUX_OR_CLKMON:    mux_value = or_clkmon;
      pcfg_pkg::MUX_CLKMON_LIVE:  mux_value = i_clkmon_status;
      pcfg_pkg::MUX_DEBUG_FIRST:  mux_value = i_debug[0];
      pcfg_pkg::MUX_DEBUG_SECOND: mux_value = i_debug[1];
      pcfg_pkg::MUX_DEBUG_THIRD:  mux_value = i_debug[2];
      default:                    mux_value = 1'b0;
    endcase
  end

  always_comb begin
    state_d       = state_q;
    state_d.oe    = i_cfg.is_output;
    // mux is ignored in input mode so the pad never sees stray data
    state_d.out   = i_cfg.is_output & mux_value;
    state_d.value = i_cfg.is_output ? mux_value : i_pin_in;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_pin_out   = state_q.out;
  assign o_pin_oe    = state_q.oe;
  assign o_pin_value = state_q.value;

endmodule // pcfg_flex_pin

// ### design/pcfg_pkg.sv
/*
  Shared constants and types for the PLL enable and flexible pin
  configuration slice. Assumes an 8-bit internal register port
  behind the serial control interface.
*/
package pcfg_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] PLL_ENABLE_WAKE_SUPPLY_ADDR = 8'h10;
  localparam logic [7:0] FLEX_PIN_DIRECTION_MUX_ADDR = 8'h18;
  localparam logic [7:0] PAD_RAIL_HOLDOVER_MAP_ADDR  = 8'h19;

  localparam logic [7:0] PLL_ENABLE_WAKE_SUPPLY_RST  = 8'h00;
  localparam logic [7:0] FLEX_PIN_DIRECTION_MUX_RST  = 8'h00;
  localparam logic [7:0] PAD_RAIL_HOLDOVER_MAP_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE         = 8'h00;

  // ==========================================================
  // field positions
  localparam int PLL_ENABLE_N_LSB     = 0;
  localparam int PLL_COUNT            = 4;
  localparam int SUPPLY_LEVEL_LSB     = 4;
  localparam int WAKE_MODE_BIT        = 6;
  localparam int WAKE_SOURCE_BIT      = 7;
  localparam int FIFTEEN_MUX_LSB      = 0;
  localparam int FIFTEEN_DIR_BIT      = 3;
  localparam int FOURTEEN_MUX_LSB     = 4;
  localparam int FOURTEEN_DIR_BIT     = 7;
  localparam int HOLDOVER_MAP_BIT     = 6;
  localparam int PADRING_SEL_EN_BIT   = 7;
  localparam int FLEX_PIN_COUNT       = 2;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    SUPPLY_1V8     = 2'b00,
    SUPPLY_2V5     = 2'b01,
    SUPPLY_3V3     = 2'b10,
    SUPPLY_INVALID = 2'b11
  } pcfg_supply_type;

  typedef enum logic [2:0] {
    MUX_CONST_LOW    = 3'b000,
    MUX_OR_ALL       = 3'b001,
    MUX_OR_PLL       = 3'b010,
    MUX_OR_CLKMON    = 3'b011,
    MUX_CLKMON_LIVE  = 3'b100,
    MUX_DEBUG_FIRST  = 3'b101,
    MUX_DEBUG_SECOND = 3'b110,
    MUX_DEBUG_THIRD  = 3'b111
  } pcfg_mux_type;

  localparam int DEBUG_COUNT = 3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] clock_loss;
    logic [3:0] freq_drift;
    logic [3:0] loss_of_lock;
    logic [3:0] holdover_freeze;
  } pcfg_notify_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pcfg_reg_req_type;

  typedef struct packed {
    logic       is_output;
    logic [2:0] mux_sel;
  } pcfg_pin_cfg_type;

endpackage : pcfg_pkg

// ### design/pcfg_top.sv
/*
  PLL enable, wake-up, supply level, flexible pin and pad rail
  configuration registers. Assumes the serial control port has been
  turned into single-cycle register read and write strobes on i_clock.
*/
// Overview of operation
// - Bits 3:0 of the PLL enable register enable PLLs D..A when cleared.
// - Bits 5:4 give the default supply level: 00 1.8 V, 01 2.5 V, 10 3.3 V.
// - The manual wake-up sequence runs only while bit 6 of that register is zero.
// - Bit 7 of that register picks which active-low wake request input drives the sequence.
// - Flex pin fourteen is an input when flex register bit 7 is zero and an output when one.
// - Flex pin fifteen direction is bit 3, its mux bits 2:0, pin fourteen mux bits 6:4, used only as outputs.
// - Mux code 001 drives the OR of all clock monitor and PLL notifications.
// - Mux code 010 drives the OR of PLL loss of lock and holdover freeze notifications.
// - Mux code 011 drives the OR of input clock loss and coarse drift notifications.
// - Code 000 drives low, code 100 the live clock monitor status, codes 101..111 debug signals.
// - Spare bit 7 set selects the pad supply by the padring bit, clear keeps the auto rail switch.
// - Spare bit 6 maps the per-PLL holdover force controls so each PLL can be forced alone.
// - With spare bit 7 set, the padring bit picks the input supply when one and the core supply when zero.
module pcfg_top (
  input  wire logic                       i_clock,
  input  wire logic                       i_arst_n,
  input  wire pcfg_pkg::pcfg_reg_req_type i_reg_req,
  output logic [7:0]                      o_reg_rdata,
  output logic                            o_reg_rvalid,
  input  wire pcfg_pkg::pcfg_notify_type  i_notify,
  input  wire logic                       i_clkmon_status,
  input  wire logic [2:0]                 i_debug,
  input  wire logic                       i_wake_request_first_n,
  input  wire logic                       i_wake_request_second_n,
  input  wire logic                       i_padring_input_sel,
  input  wire logic [3:0]                 i_holdover_force,
  input  wire logic                       i_flex_pin_fourteen_in,
  input  wire logic                       i_flex_pin_fifteen_in,
  output logic [3:0]                      o_pll_enable,
  output pcfg_pkg::pcfg_supply_type       o_default_supply_level,
  output logic                            o_manual_wake_enable,
  output logic                            o_wake_request_n,
  output logic                            o_pad_rail_auto_switch,
  output logic                            o_io_supply_rail_from_input,
  output logic [3:0]                      o_holdover_force,
  output logic                            o_flex_pin_fourteen_out,
  output logic                            o_flex_pin_fourteen_oe,
  output logic                            o_flex_pin_fourteen_value,
  output logic                            o_flex_pin_fifteen_out,
  output logic                            o_flex_pin_fifteen_oe,
  output logic                            o_flex_pin_fifteen_value
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] pll_enable_wake_supply_q;
    logic [7:0] flex_pin_direction_mux_q;
    logic [7:0] pad_rail_holdover_map_q;
    logic [7:0] rdata;
    logic       rvalid;
    logic [3:0] pll_enable;
    logic [1:0] supply;
    logic       wake_enable;
    logic       wake_request_n;
    logic       auto_switch;
    logic       io_from_input;
    logic [3:0] holdover_force;
  } pcfg_state_type;

  pcfg_state_type               state_d;
  pcfg_state_type               state_q;
  pcfg_pkg::pcfg_pin_cfg_type   pin_cfg [pcfg_pkg::FLEX_PIN_COUNT];
  logic [pcfg_pkg::FLEX_PIN_COUNT-1:0] pin_in;
  logic [pcfg_pkg::FLEX_PIN_COUNT-1:0] pin_out;
  logic [pcfg_pkg::FLEX_PIN_COUNT-1:0] pin_oe;
  logic [pcfg_pkg::FLEX_PIN_COUNT-1:0] pin_value;

  logic                           hit_pll_enable;
  logic                           hit_flex_pin;
  logic                           hit_pad_rail;
  logic [pcfg_pkg::PLL_COUNT-1:0] pll_enable_n_field;
  logic [1:0]                     supply_field;
  logic                           wake_mode_field;
  logic                           wake_source_field;
  logic                           padring_sel_en_field;
  logic                           holdover_map_field;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // the spare code is passed on as invalid rather than folded onto a legal level
  function automatic pcfg_pkg::pcfg_supply_type supply_decode(input logic [1:0] code);
    case (code)
      pcfg_pkg::SUPPLY_1V8: supply_decode = pcfg_pkg::SUPPLY_1V8;
      pcfg_pkg::SUPPLY_2V5: supply_decode = pcfg_pkg::SUPPLY_2V5;
      pcfg_pkg::SUPPLY_3V3: supply_decode = pcfg_pkg::SUPPLY_3V3;
      default:              supply_decode = pcfg_pkg::SUPPLY_INVALID;
    endcase
  endfunction

  // both pins share one layout: a direction bit and a three-bit source field
  function automatic pcfg_pkg::pcfg_pin_cfg_type pin_cfg_of(input logic [7:0] reg_value, input int dir_bit,
                                                           input int mux_lsb);
    pcfg_pkg::pcfg_pin_cfg_type cfg;
    cfg.is_output = reg_value[dir_bit];
    cfg.mux_sel   = reg_value[mux_lsb +: 3];
    return cfg;
  endfunction

  // ==========================================================
  // address decode, shared so writes and reads agree on the map
  assign hit_pll_enable = hit(i_reg_req.addr, pcfg_pkg::PLL_ENABLE_WAKE_SUPPLY_ADDR);
  assign hit_flex_pin   = hit(i_reg_req.addr, pcfg_pkg::FLEX_PIN_DIRECTION_MUX_ADDR);
  assign hit_pad_rail   = hit(i_reg_req.addr, pcfg_pkg::PAD_RAIL_HOLDOVER_MAP_ADDR);

  // ==========================================================
  // field views of the stored registers
  assign pll_enable_n_field   = state_q.pll_enable_wake_supply_q[pcfg_pkg::PLL_ENABLE_N_LSB +: pcfg_pkg::PLL_COUNT];
  assign supply_field         = state_q.pll_enable_wake_supply_q[pcfg_pkg::SUPPLY_LEVEL_LSB +: 2];
  assign wake_mode_field      = state_q.pll_enable_wake_supply_q[pcfg_pkg::WAKE_MODE_BIT];
  assign wake_source_field    = state_q.pll_enable_wake_supply_q[pcfg_pkg::WAKE_SOURCE_BIT];
  assign padring_sel_en_field = state_q.pad_rail_holdover_map_q[pcfg_pkg::PADRING_SEL_EN_BIT];
  assign holdover_map_field   = state_q.pad_rail_holdover_map_q[pcfg_pkg::HOLDOVER_MAP_BIT];

  // ==========================================================
  // register file and derived controls
  always_comb begin
    state_d = state_q;
    if (i_reg_req.wr && hit_pll_enable) begin
      state_d.pll_enable_wake_supply_q = i_reg_req.wdata;
    end
    if (i_reg_req.wr && hit_flex_pin) begin
      state_d.flex_pin_direction_mux_q = i_reg_req.wdata;
    end
    if (i_reg_req.wr && hit_pad_rail) begin
      state_d.pad_rail_holdover_map_q = i_reg_req.wdata;
    end

    // a read in the same cycle as a write still returns the old contents
    state_d.rvalid = i_reg_req.rd;
    if (i_reg_req.rd) begin
      if (hit_pll_enable) begin
        state_d.rdata = state_q.pll_enable_wake_supply_q;
      end else if (hit_flex_pin) begin
        state_d.rdata = state_q.flex_pin_direction_mux_q;
      end else if (hit_pad_rail) begin
        state_d.rdata = state_q.pad_rail_holdover_map_q;
      end else begin
        state_d.rdata = pcfg_pkg::UNMAPPED_READ_VALUE;
      end
    end

    // controls follow the stored registers one cycle later
    state_d.pll_enable  = ~pll_enable_n_field;
    state_d.supply      = supply_decode(supply_field);
    state_d.wake_enable = ~wake_mode_field;
    // request held inactive while the manual sequence is off
    if (!state_d.wake_enable) begin
      state_d.wake_request_n = 1'b1;
    end else if (wake_source_field) begin
      state_d.wake_request_n = i_wake_request_second_n;
    end else begin
      state_d.wake_request_n = i_wake_request_first_n;
    end
    state_d.auto_switch    = ~padring_sel_en_field;
    // padring bit only matters once selection is enabled; auto mode reports core supply
    state_d.io_from_input  = padring_sel_en_field & i_padring_input_sel;
    state_d.holdover_force = holdover_map_field ? i_holdover_force : 4'h0;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q                          <= '0;
      state_q.pll_enable_wake_supply_q <= pcfg_pkg::PLL_ENABLE_WAKE_SUPPLY_RST;
      state_q.flex_pin_direction_mux_q <= pcfg_pkg::FLEX_PIN_DIRECTION_MUX_RST;
      state_q.pad_rail_holdover_map_q  <= pcfg_pkg::PAD_RAIL_HOLDOVER_MAP_RST;
      state_q.wake_request_n           <= 1'b1;
      state_q.auto_switch              <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // flexible pins: index 0 is pin fourteen, index 1 is pin fifteen
  assign pin_cfg[0] = pin_cfg_of(state_q.flex_pin_direction_mux_q,
                                 pcfg_pkg::FOURTEEN_DIR_BIT, pcfg_pkg::FOURTEEN_MUX_LSB);
  assign pin_cfg[1] = pin_cfg_of(state_q.flex_pin_direction_mux_q,
                                 pcfg_pkg::FIFTEEN_DIR_BIT, pcfg_pkg::FIFTEEN_MUX_LSB);
  assign pin_in               = {i_flex_pin_fifteen_in, i_flex_pin_fourteen_in};

  for (genvar g = 0; g < pcfg_pkg::FLEX_PIN_COUNT; g++) begin : g_pin
    pcfg_flex_pin u_pin (
      .i_clock         (i_clock),
      .i_arst_n        (i_arst_n),
      .i_cfg           (pin_cfg[g]),
      .i_notify        (i_notify),
      .i_clkmon_status (i_clkmon_status),
      .i_debug         (i_debug),
      .i_pin_in        (pin_in[g]),
      .o_pin_out       (pin_out[g]),
      .o_pin_oe        (pin_oe[g]),
      .o_pin_value     (pin_value[g])
    );
  end

  // ==========================================================
  // outputs
  assign o_reg_rdata                 = state_q.rdata;
  assign o_reg_rvalid                = state_q.rvalid;
  assign o_pll_enable                = state_q.pll_enable;
  assign o_default_supply_level      = pcfg_pkg::pcfg_supply_type'(state_q.supply);
  assign o_manual_wake_enable        = state_q.wake_enable;
  assign o_wake_request_n            = state_q.wake_request_n;
  assign o_pad_rail_auto_switch      = state_q.auto_switch;
  assign o_io_supply_rail_from_input = state_q.io_from_input;
  assign o_holdover_force            = state_q.holdover_force;
  assign o_flex_pin_fourteen_out     = pin_out[0];
  assign o_flex_pin_fourteen_oe      = pin_oe[0];
  assign o_flex_pin_fourteen_value   = pin_value[0];
  assign o_flex_pin_fifteen_out      = pin_out[1];
  assign o_flex_pin_fifteen_oe       = pin_oe[1];
  assign o_flex_pin_fifteen_value    = pin_value[1];

endmodule // pcfg_top

// ### sim/pcfg_monitor.sv
/*
  Port-level checker for the configuration slice.
  Assumes it is bound to pcfg_top and sees only its ports.
*/
module pcfg_monitor (
  input wire logic                       i_clock,
  input wire logic                       i_arst_n,
  input wire pcfg_pkg::pcfg_reg_req_type i_reg_req,
  input wire logic [7:0]                 o_reg_rdata,
  input wire logic                       o_reg_rvalid,
  input wire pcfg_pkg::pcfg_notify_type  i_notify,
  input wire logic                       i_wake_request_first_n,
  input wire logic                       i_wake_request_second_n,
  input wire logic [3:0]                 i_holdover_force,
  input wire logic [3:0]                 o_pll_enable,
  input wire pcfg_pkg::pcfg_supply_type  o_default_supply_level,
  input wire logic                       o_manual_wake_enable,
  input wire logic                       o_wake_request_n,
  input wire logic                       o_pad_rail_auto_switch,
  input wire logic [3:0]                 o_holdover_force,
  input wire logic                       o_flex_pin_fourteen_out,
  input wire logic                       o_flex_pin_fourteen_oe,
  input wire logic                       o_flex_pin_fifteen_out,
  input wire logic                       o_flex_pin_fifteen_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // shadow registers, delayed one stage like the output flops
  localparam logic [2:0][7:0] ADDR = {pcfg_pkg::PAD_RAIL_HOLDOVER_MAP_ADDR,
    pcfg_pkg::FLEX_PIN_DIRECTION_MUX_ADDR, pcfg_pkg::PLL_ENABLE_WAKE_SUPPLY_ADDR};
  logic [2:0][7:0]           sh_q;
  logic [2:0][7:0]           dl_q;
  logic [7:0]                rexp_q;
  pcfg_pkg::pcfg_notify_type nq_q;
  logic                      started_q;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_q <= '0;
      dl_q <= '0;
      rexp_q <= 8'h00;
      nq_q <= '0;
      started_q <= 1'b0;
    end else begin
      // first edge after release still samples reset-time outputs
      started_q <= 1'b1;
      dl_q <= sh_q;
      nq_q <= i_notify;
      rexp_q <= pcfg_pkg::UNMAPPED_READ_VALUE;
      for (int k = 0; k < 3; k++) begin
        if (i_reg_req.addr == ADDR[k]) begin
          rexp_q <= sh_q[k];
          if (i_reg_req.wr) begin
            sh_q[k] <= i_reg_req.wdata;
          end
        end
      end
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  a_pll_enable_inverse: assert property (started_q |-> o_pll_enable == ~dl_q[0][3:0])
    else $error("pll enable not inverse of register");
  a_supply_level_code: assert property (started_q |-> o_default_supply_level == dl_q[0][5:4])
    else $error("supply level code wrong");
  a_wake_mode_gate: assert property (started_q |-> o_manual_wake_enable == !dl_q[0][6])
    else $error("manual wake enable wrong");
  a_wake_source_pick: assert property (started_q && !dl_q[0][6] |-> o_wake_request_n ==
    (dl_q[0][7] ? $past(i_wake_request_second_n) : $past(i_wake_request_first_n)))
    else $error("wake request source wrong");
  a_fourteen_dir: assert property (started_q |-> o_flex_pin_fourteen_oe == dl_q[1][7])
    else $error("pin fourteen direction wrong");
  a_fifteen_dir: assert property (started_q |-> o_flex_pin_fifteen_oe == dl_q[1][3])
    else $error("pin fifteen direction wrong");
  a_input_not_driven: assert property (!o_flex_pin_fifteen_oe |-> !o_flex_pin_fifteen_out)
    else $error("input pin driven");
  a_fourteen_undriven: assert property (!o_flex_pin_fourteen_oe |-> !o_flex_pin_fourteen_out)
    else $error("input pin fourteen driven");
  a_or_all_mux: assert property (started_q && dl_q[1][7:4] == 4'h9 |-> o_flex_pin_fourteen_out == |nq_q)
    else $error("or of all notifications wrong");
  a_or_pll_mux: assert property (started_q && dl_q[1][3:0] == 4'ha |->
    o_flex_pin_fifteen_out == |{nq_q.loss_of_lock, nq_q.holdover_freeze})
    else $error("or of pll notifications wrong");
  a_pad_rail_auto: assert property (started_q |-> o_pad_rail_auto_switch == !dl_q[2][7])
    else $error("pad rail switch wrong");
  a_holdover_map: assert property (started_q |-> o_holdover_force ==
    (dl_q[2][6] ? $past(i_holdover_force) : 4'h0))
    else $error("holdover force map wrong");
  a_read_answer: assert property (i_reg_req.rd |=> o_reg_rvalid && o_reg_rdata == rexp_q)
    else $error("read answer wrong");
endmodule : pcfg_monitor

// ### sim/test_pcfg_top.sv
/*
  Self-checking bench for pcfg_top: register accesses and pin checks.
  Assumes the design package is compiled first.
*/
module test_pcfg_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 0, arst_n = 0, clkmon = 0, wf_n = 1, ws_n = 1, pad_sel = 0, p14_in = 0, p15_in = 0;
  logic [2:0] dbg = 3'h0;
  logic [3:0] hof = 4'h0;
  pcfg_pkg::pcfg_reg_req_type req = '0;
  pcfg_pkg::pcfg_notify_type  ntf = '0;
  logic [7:0] rdata;
  logic [3:0] pll_en, ho;
  pcfg_pkg::pcfg_supply_type sup;
  logic rvalid, wk_en, wk_n, auto_sw, io_in, o14, oe14, v14, o15, oe15, v15;
  int n_fail = 0, compares = 0;
  logic [7:0] v;
  logic [7:0] pev [5] = '{8'h0e, 8'h95, 8'h2a, 8'h43, 8'h85};
  logic [15:0] stim [5] = '{16'h0000, 16'h4000, 16'h0200, 16'h0010, 16'h0008};

  pcfg_top dut (.i_clock(clk), .i_arst_n(arst_n), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_notify(ntf), .i_clkmon_status(clkmon), .i_debug(dbg),
    .i_wake_request_first_n(wf_n), .i_wake_request_second_n(ws_n), .i_padring_input_sel(pad_sel),
    .i_holdover_force(hof), .i_flex_pin_fourteen_in(p14_in), .i_flex_pin_fifteen_in(p15_in),
    .o_pll_enable(pll_en), .o_default_supply_level(sup), .o_manual_wake_enable(wk_en),
    .o_wake_request_n(wk_n), .o_pad_rail_auto_switch(auto_sw), .o_io_supply_rail_from_input(io_in),
    .o_holdover_force(ho), .o_flex_pin_fourteen_out(o14), .o_flex_pin_fourteen_oe(oe14),
    .o_flex_pin_fourteen_value(v14), .o_flex_pin_fifteen_out(o15), .o_flex_pin_fifteen_oe(oe15),
    .o_flex_pin_fifteen_value(v15));

  initial begin
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request is left standing so back-to-back calls assign once per edge
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] exp);
    req = '{addr: a, wdata: d, wr: w, rd: r};
    @(negedge clk);
    if (r) begin
      chk("rvalid", {7'h0, rvalid}, 8'h01);
      chk("rdata", rdata, exp);
    end
  endtask

  task automatic settle;
    req = '0;
    repeat (2) @(negedge clk);
  endtask

  function automatic logic mx(input logic [2:0] c);
    case (c)
      3'b000:  return 1'b0;
      3'b001:  return |ntf;
      3'b010:  return |{ntf.loss_of_lock, ntf.holdover_freeze};
      3'b011:  return |{ntf.clock_loss, ntf.freq_drift};
      3'b100:  return clkmon;
      default: return dbg[c - 3'd5];
    endcase
  endfunction

  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1;
    foreach (stim[i]) acc(1'b0, 1'b1, 8'h10 + 8'(i), 8'h00, 8'h00); // reset value of 0x10 and four unmapped addresses
    acc(1'b1, 1'b0, 8'h20, 8'hff, 8'h00);
    acc(1'b0, 1'b1, 8'h20, 8'h00, 8'h00);
    foreach (stim[i]) begin
      v = pev[i];
      wf_n = v[0];
      ws_n = !v[0];
      acc(1'b1, 1'b0, 8'h10, v, 8'h00);
      settle;
      chk("pll_en", pll_en, {~v[3:0]});
      chk("supply", sup, v[5:4]);
      chk("wake_en", wk_en, !v[6]);
      chk("wake_n", wk_n, v[6] | (v[7] ? ws_n : wf_n));
      acc(1'b0, 1'b1, 8'h10, 8'h00, v);
    end
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 1'b0, 8'h18, {1'b1, 3'(c), 1'b1, 3'(c)}, 8'h00);
      foreach (stim[s]) begin
        ntf = stim[s];
        clkmon = s[0];
        dbg = s[0] ? 3'b101 : 3'b010;
        settle;
        chk("oe", {oe14, oe15}, 8'h03);
        chk("out14", o14, mx(3'(c)));
        chk("out15", {o15, v14}, {2{mx(3'(c))}});
      end
    end
    acc(1'b1, 1'b0, 8'h18, 8'h97, 8'h00);
    p15_in = 1;
    dbg = 3'b111;
    settle;
    chk("pin15 input", {oe15, o15, v15}, 8'h01);
    chk("pin14 output", o14, |ntf);
    acc(1'b1, 1'b0, 8'h18, 8'h79, 8'h00);
    p14_in = 1;
    settle;
    chk("pin14 input", {oe14, o14, v14}, 8'h01);
    chk("pin15 output", {oe15, o15}, {1'b1, |ntf});
    pad_sel = 1;
    acc(1'b1, 1'b0, 8'h19, 8'h80, 8'h00);
    settle;
    chk("pad sel on", {auto_sw, io_in}, 8'h01);
    pad_sel = 0;
    settle;
    chk("pad core", io_in, 8'h00);
    pad_sel = 1;
    hof = 4'ha;
    acc(1'b1, 1'b0, 8'h19, 8'h40, 8'h00);
    settle;
    chk("holdover", {auto_sw, io_in, ho}, 8'h2a);
    acc(1'b1, 1'b0, 8'h10, 8'h5a, 8'h00);
    acc(1'b1, 1'b1, 8'h10, 8'h33, 8'h5a);
    acc(1'b0, 1'b1, 8'h10, 8'h00, 8'h33);
    arst_n = 0;
    settle;
    arst_n = 1;
    acc(1'b0, 1'b1, 8'h18, 8'h00, 8'h00);
    acc(1'b0, 1'b1, 8'h19, 8'h00, 8'h00);
    chk("pll_en after reset", pll_en, 8'h0f);
    chk("oe after reset", {oe14, oe15}, 8'h00);
    settle;
    tally_and_finish;
  end
endmodule : test_pcfg_top

bind pcfg_top pcfg_monitor u_mon (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_reg_req(i_reg_req),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_notify(i_notify),
  .i_wake_request_first_n(i_wake_request_first_n), .i_wake_request_second_n(i_wake_request_second_n),
  .i_holdover_force(i_holdover_force), .o_pll_enable(o_pll_enable),
  .o_default_supply_level(o_default_supply_level), .o_manual_wake_enable(o_manual_wake_enable),
  .o_wake_request_n(o_wake_request_n), .o_pad_rail_auto_switch(o_pad_rail_auto_switch),
  .o_holdover_force(o_holdover_force), .o_flex_pin_fourteen_out(o_flex_pin_fourteen_out),
  .o_flex_pin_fourteen_oe(o_flex_pin_fourteen_oe), .o_flex_pin_fifteen_out(o_flex_pin_fifteen_out),
  .o_flex_pin_fifteen_oe(o_flex_pin_fifteen_oe));
